// ==== logic/bbg_gain_map.sv ====
`timescale 1ns/1ps
module bbg_gain_map
  import bbg_pkg::*;
(
  // Gain code in
  input wire logic [GAIN_W-1:0] gain_code,
  // Attenuation below max, in half dB
  output logic [ATTEN_W-1:0] atten_half_db
);

  logic [GAIN_W-1:0] below;

  // Half-dB steps at the top, paired codes per 1 dB below [RULE13]
  always_comb
  begin
    below = '0;
    if (gain_code >= GAIN_FINE_LOW)
    begin
      atten_half_db = GAIN_TOP - gain_code;
    end
    else
    begin
      below = GAIN_COARSE_TOP - gain_code;
      atten_half_db = COARSE_BASE_HALF_DB + {below[GAIN_W-1:1], 1'b0};
    end
  end

endmodule : bbg_gain_map

// ==== logic/bbg_pkg.sv ====
package bbg_pkg;

  // ----------------------------------------------------------------
  // Serial word layout
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 14;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned WORD_W = DATA_W + ADDR_W;
  localparam int unsigned BITCNT_W = 5;
  localparam logic [BITCNT_W-1:0] WORD_BITS = 5'h12;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_FILTER_TRIM = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_FILTER_MODE_AND_INDICATOR_SELECT = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_TRANSMIT_GAIN_SOURCE = 4'h9;
  localparam logic [ADDR_W-1:0] ADDR_TRANSMIT_GAIN_CODE = 4'hc;
  localparam logic [ADDR_W-1:0] ADDR_OUTPUT_COMMON_MODE_TRIM = 4'hf;

  // Reset value of every register
  localparam logic [DATA_W-1:0] REG_RESET = 14'h0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned RX_FINE_LSB = 0;
  localparam int unsigned TX_FINE_LSB = 3;
  localparam int unsigned HP_CORNER_LSB = 12;
  localparam int unsigned COARSE_LSB = 0;
  localparam int unsigned IND_SEL_LSB = 8;
  localparam int unsigned IND_GATE_BIT = 10;
  localparam int unsigned GAIN_SRC_BIT = 10;
  localparam int unsigned GAIN_CODE_LSB = 0;
  localparam int unsigned CM_TRIM_LSB = 10;

  localparam int unsigned GAIN_W = 6;
  localparam int unsigned ATTEN_W = 6;
  localparam int unsigned PCT_W = 7;

  // Fine trim scaling
  localparam logic [PCT_W-1:0] FINE_BASE_PCT = 7'h5a;
  localparam logic [PCT_W-1:0] FINE_STEP_PCT = 7'h05;
  localparam logic [2:0] RX_FINE_MAX = 3'h4;
  localparam logic [2:0] TX_FINE_MAX = 3'h5;

  // Gain map breakpoints, attenuation in half dB
  localparam logic [GAIN_W-1:0] GAIN_TOP = 6'h3f;
  localparam logic [GAIN_W-1:0] GAIN_FINE_LOW = 6'h30;
  localparam logic [GAIN_W-1:0] GAIN_COARSE_TOP = 6'h2f;
  localparam logic [ATTEN_W-1:0] COARSE_BASE_HALF_DB = 6'h10;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BBG_HP_600K,
    BBG_HP_100,
    BBG_HP_4K,
    BBG_HP_30K
  } bbg_hp_t;

  typedef enum logic [1:0] {
    BBG_IND_NONE,
    BBG_IND_RSSI,
    BBG_IND_TEMP,
    BBG_IND_PDET
  } bbg_ind_t;

endpackage : bbg_pkg

// ==== logic/bbg_serial_rx.sv ====
`timescale 1ns/1ps
module bbg_serial_rx
  import bbg_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Synchronised serial pins
  input wire logic ser_cs_n,
  input wire logic ser_clk,
  input wire logic ser_din,
  // Write strobe out
  bbg_wr_if.src wr
);

  logic sclk_d_ff;
  logic cs_d_ff;
  logic [WORD_W-1:0] shift_ff;
  logic [BITCNT_W-1:0] cnt_ff;

  // Edge history of the synchronised pins
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sclk_d_ff <= 1'b0;
      cs_d_ff <= 1'b1;
    end
    else
    begin
      sclk_d_ff <= ser_clk;
      cs_d_ff <= ser_cs_n;
    end
  end

  // Shift in MSB first on each rising serial clock while selected
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      shift_ff <= '0;
      cnt_ff <= '0;
    end
    else if (ser_cs_n)
    begin
      cnt_ff <= '0;
    end
    else if (ser_clk && !sclk_d_ff)
    begin
      shift_ff <= {shift_ff[WORD_W-2:0], ser_din};
      if (cnt_ff != WORD_BITS)
      begin
        cnt_ff <= cnt_ff + 5'h01;
      end
    end
  end

  // Commit on deselect only after a whole word or more has been shifted in; short frames are dropped
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      wr.wr_stb <= 1'b0;
      wr.wr_addr <= '0;
      wr.wr_data <= '0;
    end
    else
    begin
      wr.wr_stb <= ser_cs_n && !cs_d_ff && (cnt_ff == WORD_BITS);
      wr.wr_addr <= shift_ff[ADDR_W-1:0];
      wr.wr_data <= shift_ff[WORD_W-1:ADDR_W];
    end
  end

endmodule : bbg_serial_rx

// ==== logic/bbg_top.sv ====
`timescale 1ns/1ps
// Behaviour
// RULE1: Coupling pin high forces the 600 kHz AC-coupled high-pass corner.
// RULE2: Coupling pin low uses the near-DC field: 00 100 Hz, X1 4 kHz, 10 30 kHz.
// RULE3: Coarse field sets receive lowpass 7.5, 8.5, 15 or 18 MHz.
// RULE4: Receive fine field scales the coarse corner 90 to 110 percent.
// RULE5: Common-mode field trims receive output level up from 1.1 V toward 1.4 V.
// RULE6: Indicator select routes strength, temperature or power detector.
// RULE7: Gating bit clear with pin low gives no output, otherwise the source is output.
// RULE8: Strength source is output only in receive mode.
// RULE9: Transmitter enabled only with direction pin high and shutdown pin high.
// RULE10: Coarse field sets transmit lowpass 8, 11, 16.5 or 22.5 MHz.
// RULE11: Transmit fine field scales 90 to 115 percent, higher codes unused.
// RULE12: Transmit gain is a six-bit code from the register or the gain pins.
// RULE13: Gain codes 63 to 48 step 0.5 dB, lower codes pair per 1 dB down to 31 dB.
// RULE14: Source bit clear picks the gain pins, set picks the register code.
// RULE15: Receiver enabled only with direction pin low and shutdown pin high.
// RULE16: Fields hold their last write and reset to zero.
module bbg_top
  import bbg_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Three-wire serial port
  input wire logic ser_cs_n,
  input wire logic ser_clk,
  input wire logic ser_din,
  // Mode and gain pins
  input wire logic coupling_select_pin,
  input wire logic direction_select_pin,
  input wire logic shutdown_pin,
  input wire logic [GAIN_W-1:0] parallel_gain_pins,
  // Path enables
  output logic rx_enable,
  output logic tx_enable,
  // Receive filter settings
  output bbg_hp_t rx_hp_corner,
  output logic [1:0] rx_lpf_coarse,
  output logic [PCT_W-1:0] rx_lpf_fine_pct,
  output logic [1:0] rx_cm_trim,
  // Transmit filter settings
  output logic [1:0] tx_lpf_coarse,
  output logic [PCT_W-1:0] tx_lpf_fine_pct,
  output logic tx_fine_unused,
  // Strength indicator routing
  output bbg_ind_t indicator_source,
  // Transmit gain
  output logic [GAIN_W-1:0] tx_gain_code,
  output logic [ATTEN_W-1:0] tx_atten_half_db
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned NSYNC = 6 + GAIN_W;

  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  logic cs_s;
  logic sclk_s;
  logic din_s;
  logic hp_pin_s;
  logic dir_pin_s;
  logic shutdown_pin_s;
  logic [GAIN_W-1:0] gain_pins_s;

  // Two stages on every pin; pins idle deselected and shut down
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sync1_ff <= {{GAIN_W{1'b0}}, 6'h01};
      sync2_ff <= {{GAIN_W{1'b0}}, 6'h01};
    end
    else
    begin
      sync1_ff <= {parallel_gain_pins, shutdown_pin, direction_select_pin,
                   coupling_select_pin, ser_din, ser_clk, ser_cs_n};
      sync2_ff <= sync1_ff;
    end
  end

  assign cs_s = sync2_ff[0];
  assign sclk_s = sync2_ff[1];
  assign din_s = sync2_ff[2];
  assign hp_pin_s = sync2_ff[3];
  assign dir_pin_s = sync2_ff[4];
  assign shutdown_pin_s = sync2_ff[5];
  assign gain_pins_s = sync2_ff[NSYNC-1:6];

  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  bbg_wr_if wr_bus ();

  bbg_serial_rx u_serial_rx (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .ser_cs_n(cs_s),
    .ser_clk(sclk_s),
    .ser_din(din_s),
    .wr(wr_bus)
  );

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] filter_trim_ff;
  logic [DATA_W-1:0] filter_mode_ff;
  logic [DATA_W-1:0] gain_source_ff;
  logic [DATA_W-1:0] gain_code_ff;
  logic [DATA_W-1:0] cm_trim_ff;

  // Each register holds until a write to its own address [RULE16]
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      filter_trim_ff <= REG_RESET;
      filter_mode_ff <= REG_RESET;
      gain_source_ff <= REG_RESET;
      gain_code_ff <= REG_RESET;
      cm_trim_ff <= REG_RESET;
    end
    else if (wr_bus.wr_stb)
    begin
      // Other addresses belong to sections outside this block
      if (wr_bus.wr_addr == ADDR_FILTER_TRIM)
      begin
        filter_trim_ff <= wr_bus.wr_data;
      end
      else if (wr_bus.wr_addr == ADDR_FILTER_MODE_AND_INDICATOR_SELECT)
      begin
        filter_mode_ff <= wr_bus.wr_data;
      end
      else if (wr_bus.wr_addr == ADDR_TRANSMIT_GAIN_SOURCE)
      begin
        gain_source_ff <= wr_bus.wr_data;
      end
      else if (wr_bus.wr_addr == ADDR_TRANSMIT_GAIN_CODE)
      begin
        gain_code_ff <= wr_bus.wr_data;
      end
      else if (wr_bus.wr_addr == ADDR_OUTPUT_COMMON_MODE_TRIM)
      begin
        cm_trim_ff <= wr_bus.wr_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  logic [1:0] hp_field;
  logic [1:0] coarse_field;
  logic [2:0] rx_fine_field;
  logic [2:0] tx_fine_field;
  logic [1:0] ind_sel_field;
  logic ind_gate_bit;
  logic gain_src_bit;

  assign hp_field = filter_trim_ff[HP_CORNER_LSB +: 2];
  assign rx_fine_field = filter_trim_ff[RX_FINE_LSB +: 3];
  assign tx_fine_field = filter_trim_ff[TX_FINE_LSB +: 3];
  assign coarse_field = filter_mode_ff[COARSE_LSB +: 2];
  assign ind_sel_field = filter_mode_ff[IND_SEL_LSB +: 2];
  assign ind_gate_bit = filter_mode_ff[IND_GATE_BIT];
  assign gain_src_bit = gain_source_ff[GAIN_SRC_BIT];

  // Fine code to percent of coarse corner, clamped at the top code
  function automatic logic [PCT_W-1:0] bbg_fine_pct(input logic [2:0] code,
                                                   input logic [2:0] top);
    logic [2:0] c;
    c = (code > top) ? top : code;
    return FINE_BASE_PCT + PCT_W'(c * FINE_STEP_PCT);
  endfunction : bbg_fine_pct

  // ----------------------------------------------------------------
  // Path enables
  // ----------------------------------------------------------------
  logic nxt_rx_en;
  logic nxt_tx_en;
  logic rx_en_ff;
  logic tx_en_ff;

  assign nxt_rx_en = !dir_pin_s && shutdown_pin_s; // [RULE15]
  assign nxt_tx_en = dir_pin_s && shutdown_pin_s; // [RULE9]

  // Enables registered so they never glitch across a pin change
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rx_en_ff <= 1'b0;
      tx_en_ff <= 1'b0;
    end
    else
    begin
      rx_en_ff <= nxt_rx_en;
      tx_en_ff <= nxt_tx_en;
    end
  end

  assign rx_enable = rx_en_ff;
  assign tx_enable = tx_en_ff;

  // ----------------------------------------------------------------
  // Receive filter decode
  // ----------------------------------------------------------------
  bbg_hp_t nxt_hp;
  bbg_hp_t hp_ff;

  // Pin overrides the near-DC field entirely
  always_comb
  begin
    if (hp_pin_s)
    begin
      nxt_hp = BBG_HP_600K; // [RULE1]
    end
    else if (hp_field[0])
    begin
      nxt_hp = BBG_HP_4K; // [RULE2]
    end
    else if (hp_field[1])
    begin
      nxt_hp = BBG_HP_30K; // [RULE2]
    end
    else
    begin
      nxt_hp = BBG_HP_100; // [RULE2]
    end
  end

  logic [1:0] rx_coarse_ff;
  logic [PCT_W-1:0] rx_fine_ff;
  logic [1:0] cm_ff;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      hp_ff <= BBG_HP_100;
      rx_coarse_ff <= 2'h0;
      rx_fine_ff <= FINE_BASE_PCT;
      cm_ff <= 2'h0;
    end
    else
    begin
      hp_ff <= nxt_hp;
      rx_coarse_ff <= coarse_field; // [RULE3]
      rx_fine_ff <= bbg_fine_pct(rx_fine_field, RX_FINE_MAX); // [RULE4]
      cm_ff <= cm_trim_ff[CM_TRIM_LSB +: 2]; // [RULE5]
    end
  end

  assign rx_hp_corner = hp_ff;
  assign rx_lpf_coarse = rx_coarse_ff;
  assign rx_lpf_fine_pct = rx_fine_ff;
  assign rx_cm_trim = cm_ff;

  // ----------------------------------------------------------------
  // Transmit filter decode
  // ----------------------------------------------------------------
  logic [1:0] tx_coarse_ff;
  logic [PCT_W-1:0] tx_fine_ff;
  logic tx_unused_ff;

  // Unused fine codes hold the 115 percent setting and are flagged
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      tx_coarse_ff <= 2'h0;
      tx_fine_ff <= FINE_BASE_PCT;
      tx_unused_ff <= 1'b0;
    end
    else
    begin
      tx_coarse_ff <= coarse_field; // [RULE10]
      tx_fine_ff <= bbg_fine_pct(tx_fine_field, TX_FINE_MAX); // [RULE11]
      tx_unused_ff <= tx_fine_field > TX_FINE_MAX; // [RULE11]
    end
  end

  assign tx_lpf_coarse = tx_coarse_ff;
  assign tx_lpf_fine_pct = tx_fine_ff;
  assign tx_fine_unused = tx_unused_ff;

  // ----------------------------------------------------------------
  // Strength indicator routing
  // ----------------------------------------------------------------
  bbg_ind_t nxt_ind;
  bbg_ind_t ind_ff;

  // Select code 11 has no source and reads as no signal
  always_comb
  begin
    if (!ind_gate_bit && !hp_pin_s)
    begin
      nxt_ind = BBG_IND_NONE; // [RULE7]
    end
    else if (ind_sel_field == 2'h0)
    begin
      nxt_ind = nxt_rx_en ? BBG_IND_RSSI : BBG_IND_NONE; // [RULE6] [RULE8]
    end
    else if (ind_sel_field == 2'h1)
    begin
      nxt_ind = BBG_IND_TEMP; // [RULE6]
    end
    else if (ind_sel_field == 2'h2)
    begin
      nxt_ind = BBG_IND_PDET; // [RULE6]
    end
    else
    begin
      nxt_ind = BBG_IND_NONE;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ind_ff <= BBG_IND_NONE;
    end
    else
    begin
      ind_ff <= nxt_ind;
    end
  end

  assign indicator_source = ind_ff;

  // ----------------------------------------------------------------
  // Transmit gain
  // ----------------------------------------------------------------
  logic [GAIN_W-1:0] nxt_gain;
  logic [GAIN_W-1:0] gain_ff;
  logic [ATTEN_W-1:0] nxt_atten;
  logic [ATTEN_W-1:0] atten_ff;

  // Pins when clear, register when set [RULE14] [RULE12]
  assign nxt_gain = gain_src_bit ? gain_code_ff[GAIN_CODE_LSB +: GAIN_W] : gain_pins_s;

  bbg_gain_map u_gain_map (
    .gain_code(nxt_gain),
    .atten_half_db(nxt_atten)
  );

  // Code and attenuation registered together so they agree from the first edge after reset
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      gain_ff <= '0;
      atten_ff <= '0;
    end
    else
    begin
      gain_ff <= nxt_gain;
      atten_ff <= nxt_atten; // [RULE13]
    end
  end

  assign tx_gain_code = gain_ff;
  assign tx_atten_half_db = atten_ff;

endmodule : bbg_top

// ==== logic/bbg_wr_if.sv ====
`timescale 1ns/1ps
// Register write strobe from serial port to register bank
interface bbg_wr_if;
  import bbg_pkg::*;
  logic wr_stb;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  modport src (output wr_stb, output wr_addr, output wr_data);
  modport dst (input wr_stb, input wr_addr, input wr_data);
endinterface : bbg_wr_if

// ==== testbench/baseband_filter_gain_control_test.sv ====
`timescale 1ns/1ps
module baseband_filter_gain_control_test;
  import bbg_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rxe, txe, unu;
    logic [1:0] hp, crs, cm, ind;
    logic [6:0] rxf, txf;
    logic [5:0] gc, at;
  } bbg_exp_t;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic csp = 1'b0, dir = 1'b0, pwr = 1'b0;
  logic [GAIN_W-1:0] gpins = 6'h00;
  logic ser_cs_n, ser_clk, ser_din, rxe, txe, unu;
  bbg_hp_t hp;
  bbg_ind_t ind;
  logic [1:0] rxc, txc, cm;
  logic [PCT_W-1:0] rxf, txf;
  logic [GAIN_W-1:0] gc;
  logic [ATTEN_W-1:0] at;
  logic [DATA_W-1:0] r7 = '0, r8 = '0, r9 = '0, r12 = '0, r15 = '0;
  logic [3:0] adr [6] = '{4'h7, 4'h8, 4'h9, 4'hc, 4'hf, 4'he};
  int miscompares = 0, check_count = 0;
  bbg_exp_t expq[$];
  event sample_ev;

  // 40 MHz clock
  initial
  begin
    forever #12.5 core_clk = ~core_clk;
  end

  bbg_ctl_model u_ctl (.core_clk(core_clk), .ser_cs_n(ser_cs_n), .ser_clk(ser_clk),
    .ser_din(ser_din));
  bbg_top u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .ser_cs_n(ser_cs_n), .ser_clk(ser_clk), .ser_din(ser_din),
    .coupling_select_pin(csp), .direction_select_pin(dir), .shutdown_pin(pwr),
    .parallel_gain_pins(gpins), .rx_enable(rxe), .tx_enable(txe),
    .rx_hp_corner(hp), .rx_lpf_coarse(rxc), .rx_lpf_fine_pct(rxf), .rx_cm_trim(cm),
    .tx_lpf_coarse(txc), .tx_lpf_fine_pct(txf), .tx_fine_unused(unu),
    .indicator_source(ind), .tx_gain_code(gc), .tx_atten_half_db(at));

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  function automatic logic [6:0] pct(input logic [2:0] c, input logic [2:0] mx);
    return 7'h5a + 7'h05 * ((c > mx) ? mx : c);
  endfunction : pct

  function automatic bbg_exp_t model();
    bbg_exp_t e;
    e.gc = r9[10] ? r12[5:0] : gpins;
    e.at = (e.gc >= 6'h30) ? 6'h3f - e.gc : 6'h10 + ((6'h2f - e.gc) & 6'h3e);
    e.rxe = !dir && pwr;
    e.txe = dir && pwr;
    e.hp = csp ? BBG_HP_600K : (r7[12] ? BBG_HP_4K : (r7[13] ? BBG_HP_30K : BBG_HP_100));
    e.crs = r8[1:0];
    e.rxf = pct(r7[2:0], 3'h4);
    e.txf = pct(r7[5:3], 3'h5);
    e.unu = (r7[5:4] == 2'h3);
    e.cm = r15[11:10];
    e.ind = (r8[9:8] == 2'h1) ? BBG_IND_TEMP : (r8[9:8] == 2'h2) ? BBG_IND_PDET :
      (r8[9:8] == 2'h0 && e.rxe) ? BBG_IND_RSSI : BBG_IND_NONE;
    if (!r8[10] && !csp)
      e.ind = BBG_IND_NONE;
    return e;
  endfunction : model

  // ----------------------------------------------------------------
  // Drivers and checker
  // ----------------------------------------------------------------
  task automatic pins(input logic [8:0] v);
    @(posedge core_clk);
    {csp, dir, pwr, gpins} <= v;
  endtask : pins

  // Shadow copy follows only whole frames to mapped addresses
  task automatic wr(input logic [3:0] a, input logic [13:0] d, input int n, input int ph);
    u_ctl.send(a, d, n, ph);
    if (n == 18)
      case (a)
        4'h7: r7 = d;
        4'h8: r8 = d;
        4'h9: r9 = d;
        4'hc: r12 = d;
        4'hf: r15 = d;
        default: ;
      endcase
  endtask : wr

  // Six edges cover both the pin and the write latency
  task automatic settle();
    repeat (6) @(posedge core_clk);
    #1;
    expq.push_back(model());
    -> sample_ev;
  endtask : settle

  task automatic chk(input logic [6:0] g, input logic [6:0] e);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic test_done();
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  always @(sample_ev)
  begin
    bbg_exp_t e;
    e = expq.pop_front();
    chk(rxe, e.rxe);
    chk(txe, e.txe);
    chk(hp, e.hp);
    chk(rxc, e.crs);
    chk(txc, e.crs);
    chk(rxf, e.rxf);
    chk(txf, e.txf);
    chk(unu, e.unu);
    chk(cm, e.cm);
    chk(ind, e.ind);
    chk(gc, e.gc);
    chk(at, e.at);
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    int i;
    void'($urandom(32'h7123));
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    settle();
    // Every code of every field; pin source takes gain codes with bit 3 clear, register source those with bit 3 set
    for (i = 0; i < 64; i++)
    begin
      pins({i[0], i[1], i[2], i[5:0]});
      wr(4'h7, {i[4:3], 6'h00, i[5:0]}, 18, 3);
      wr(4'h8, {3'h0, i[5], i[4:3], 6'h00, i[1:0]}, 18, 3);
      wr(4'h9, {3'h0, i[3], 10'h000}, 18, 3);
      wr(4'hc, {8'h00, i[5:0] ^ 6'h10}, 18, 3);
      wr(4'hf, {2'h0, i[2:1], 10'h000}, 18, 3);
      settle();
    end
    // Short frame and unmapped address leave everything as it was
    wr(4'hf, 14'h3c00, 17, 4);
    wr(4'he, 14'h3fff, 18, 5);
    settle();
    for (i = 0; i < 40; i++)
    begin
      pins(9'($urandom));
      wr(adr[$urandom_range(5, 0)], 14'($urandom), 18, $urandom_range(5, 3));
      settle();
    end
    // Reset in mid-run clears every field
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    {r7, r8, r9, r12, r15} = '0;
    settle();
    repeat (2) @(posedge core_clk);
    test_done();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #(25 * 60000);
    miscompares++;
    test_done();
  end
endmodule : baseband_filter_gain_control_test

// ==== testbench/bbg_ctl_model.sv ====
`timescale 1ns/1ps
module bbg_ctl_model
  import bbg_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Serial pins toward the device
  output logic ser_cs_n,
  output logic ser_clk,
  output logic ser_din
);
  logic cs_q = 1'b1;
  logic ck_q = 1'b0;
  logic d_q = 1'b0;

  // Bit clock stands still low outside frames
  assign ser_cs_n = cs_q;
  assign ser_clk = ck_q;
  assign ser_din = d_q;

  // One frame, data then address, MSB first; ph sets the speed
  task automatic send(input logic [3:0] a, input logic [13:0] d, input int n, input int ph);
    logic [WORD_W-1:0] w;
    int b;
    w = {d, a};
    @(posedge core_clk);
    cs_q <= 1'b0;
    for (b = 0; b < n; b++)
    begin
      d_q <= w[WORD_W-1-b];
      repeat (ph) @(posedge core_clk);
      ck_q <= 1'b1;
      repeat (ph) @(posedge core_clk);
      ck_q <= 1'b0;
    end
    repeat (ph) @(posedge core_clk);
    cs_q <= 1'b1;
    d_q <= ~d_q; // Released line must not echo the last bit
    repeat (4) @(posedge core_clk);
  endtask : send
endmodule : bbg_ctl_model

// ==== testbench/bbg_top_chk.sv ====
`timescale 1ns/1ps
module bbg_top_chk
  import bbg_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Pins
  input wire logic ser_cs_n,
  input wire logic coupling_select_pin,
  input wire logic direction_select_pin,
  input wire logic shutdown_pin,
  // Decoded outputs
  input wire logic rx_enable,
  input wire logic tx_enable,
  input wire bbg_hp_t rx_hp_corner,
  input wire logic [1:0] rx_lpf_coarse,
  input wire logic [PCT_W-1:0] rx_lpf_fine_pct,
  input wire logic [1:0] rx_cm_trim,
  input wire logic [1:0] tx_lpf_coarse,
  input wire logic [PCT_W-1:0] tx_lpf_fine_pct,
  input wire logic tx_fine_unused,
  input wire bbg_ind_t indicator_source,
  input wire logic [GAIN_W-1:0] tx_gain_code,
  input wire logic [ATTEN_W-1:0] tx_atten_half_db
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic [1:0] up_ff;
  logic ok;

  // Pin history is only meaningful once the sync stages have refilled
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      up_ff <= 2'h0;
    else if (up_ff != 2'h3)
      up_ff <= up_ff + 2'h1;
  end
  assign ok = (up_ff == 2'h3);

  // Attenuation in half dB below max
  function automatic logic [ATTEN_W-1:0] att_of(input logic [GAIN_W-1:0] c);
    return (c >= 6'h30) ? 6'h3f - c : 6'h10 + ((6'h2f - c) & 6'h3e);
  endfunction : att_of

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  tx_enable_a: assert property (ok |->
    tx_enable == $past(direction_select_pin && shutdown_pin, 3))
    else $error("Transmit enable does not follow the mode pins");
  rx_enable_a: assert property (ok |->
    rx_enable == $past(!direction_select_pin && shutdown_pin, 3))
    else $error("Receive enable does not follow the mode pins");
  hp_forced_a: assert property (ok && $past(coupling_select_pin, 3) |->
    rx_hp_corner == BBG_HP_600K)
    else $error("Coupling pin high without the wide corner");
  hp_field_a: assert property (ok && !$past(coupling_select_pin, 3) |->
    rx_hp_corner != BBG_HP_600K)
    else $error("Wide corner with coupling pin low");
  rssi_mode_a: assert property (ok && indicator_source == BBG_IND_RSSI |->
    rx_enable)
    else $error("Strength output outside receive mode");
  coarse_pair_a: assert property ((ok && ser_cs_n) [*8] |=>
    $stable(rx_lpf_coarse) && rx_lpf_coarse == tx_lpf_coarse)
    else $error("Coarse corners disagree or changed without a write");
  rx_fine_a: assert property (rx_lpf_fine_pct inside
    {7'h5a, 7'h5f, 7'h64, 7'h69, 7'h6e})
    else $error("Receive fine percent out of table");
  tx_unused_a: assert property (tx_fine_unused |->
    tx_lpf_fine_pct == 7'h73)
    else $error("Unused transmit fine code not clamped");
  gain_map_a: assert property (ok && tx_gain_code == $past(tx_gain_code) |->
    tx_atten_half_db == att_of(tx_gain_code))
    else $error("Attenuation does not match gain code");
  cm_hold_a: assert property ((ok && ser_cs_n) [*8] |=>
    $stable(rx_cm_trim))
    else $error("Trim changed without a serial write");

  // Main scenarios
  cover property (tx_enable);
  cover property (indicator_source == BBG_IND_PDET);
  cover property (tx_fine_unused);
endmodule : bbg_top_chk

bind bbg_top bbg_top_chk u_chk (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .ser_cs_n(ser_cs_n),
  .coupling_select_pin(coupling_select_pin),
  .direction_select_pin(direction_select_pin),
  .shutdown_pin(shutdown_pin),
  .rx_enable(rx_enable),
  .tx_enable(tx_enable),
  .rx_hp_corner(rx_hp_corner),
  .rx_lpf_coarse(rx_lpf_coarse),
  .rx_lpf_fine_pct(rx_lpf_fine_pct),
  .rx_cm_trim(rx_cm_trim),
  .tx_lpf_coarse(tx_lpf_coarse),
  .tx_lpf_fine_pct(tx_lpf_fine_pct),
  .tx_fine_unused(tx_fine_unused),
  .indicator_source(indicator_source),
  .tx_gain_code(tx_gain_code),
  .tx_atten_half_db(tx_atten_half_db)
);
